// >>> hw/srb_pkg.sv
// Constants, carriers and state type of the status register bank
package srb_pkg;

  localparam int SRB_DW = 16;
  localparam int SRB_AW = 8;
  localparam int SRB_NREG = 22;
  localparam int SRB_NBLK = 2;

  localparam logic [7:0] OFS_VERSION_INFO = 8'h00;
  localparam logic [7:0] OFS_CHAIN_ADDRESS = 8'h01;
  localparam logic [7:0] OFS_STATUS_ONE = 8'h02;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h03;
  localparam logic [7:0] OFS_STATUS_THREE = 8'h04;
  localparam logic [7:0] OFS_FAULT_ONE = 8'h05;
  localparam logic [7:0] OFS_FAULT_TWO = 8'h06;
  localparam logic [7:0] OFS_ALERT_SUMMARY = 8'h07;
  localparam logic [7:0] OFS_CELL_OV = 8'h08;
  localparam logic [7:0] OFS_CELL_UV = 8'h09;
  localparam logic [7:0] OFS_EXTREME_CELL = 8'h0a;
  localparam logic [7:0] OFS_AUX_PROTECT = 8'h0b;
  localparam logic [7:0] OFS_AUX_OV = 8'h0c;
  localparam logic [7:0] OFS_CFG_ONE = 8'h14;
  localparam logic [7:0] OFS_CFG_TWO = 8'h15;
  localparam logic [7:0] OFS_STATUS_LAST = 8'h0c;

  localparam logic [15:0] MASK_CHAIN_ADDRESS = 16'hffe0;
  localparam logic [15:0] MASK_STATUS_ONE = 16'hffbf;
  localparam logic [15:0] MASK_STATUS_TWO = 16'hfef1;
  localparam logic [15:0] MASK_STATUS_THREE = 16'hf800;
  localparam logic [15:0] MASK_FAULT_ONE = 16'hffff;
  localparam logic [15:0] MASK_FAULT_TWO = 16'hf80f;
  localparam logic [15:0] MASK_ALERT_SUMMARY = 16'hff1f;
  localparam logic [15:0] MASK_CELL = 16'h3fff;
  localparam logic [15:0] MASK_EXTREME_CELL = 16'h0f0f;
  localparam logic [15:0] MASK_AUX = 16'h003f;
  localparam logic [15:0] MASK_CFG_ONE = 16'hffff;
  localparam logic [15:0] MASK_CFG_TWO = 16'hef77;

  localparam int POS_CFG_ONE_SPARE = 3;
  localparam int POS_CFG_TWO_SPARE = 8;
  localparam int W_CFG_TWO_SPARE = 4;
  localparam int POS_S1_PEC = 5;
  localparam int POS_S1_INTERFACE = 4;
  localparam int POS_S2_SERIAL = 7;
  localparam int POS_S2_REJECTED = 0;

  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [7:0] CRC_POLY = 8'ha6;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef struct packed {
    logic valid;
    logic write;
    logic [SRB_AW-1:0] addr;
    logic [SRB_DW-1:0] data;
    logic [7:0] check;
    logic proto_err;
  } srb_req_t;

  typedef struct packed {
    logic valid;
    logic rejected;
    logic [SRB_DW-1:0] data;
    logic [7:0] check;
  } srb_rsp_t;

  typedef struct packed {
    logic [SRB_NREG-1:0][SRB_DW-1:0] regs;
    srb_rsp_t rsp;
  } srb_state_t;

  // Implemented bits of each offset; zero where nothing is stored, except the live extreme cell offset
  function automatic logic [15:0] srb_mask(input logic [7:0] a);
    case (a)
      OFS_CHAIN_ADDRESS: srb_mask = MASK_CHAIN_ADDRESS;
      OFS_STATUS_ONE: srb_mask = MASK_STATUS_ONE;
      OFS_STATUS_TWO: srb_mask = MASK_STATUS_TWO;
      OFS_STATUS_THREE: srb_mask = MASK_STATUS_THREE;
      OFS_FAULT_ONE: srb_mask = MASK_FAULT_ONE;
      OFS_FAULT_TWO: srb_mask = MASK_FAULT_TWO;
      OFS_ALERT_SUMMARY: srb_mask = MASK_ALERT_SUMMARY;
      OFS_CELL_OV: srb_mask = MASK_CELL;
      OFS_CELL_UV: srb_mask = MASK_CELL;
      OFS_EXTREME_CELL: srb_mask = MASK_EXTREME_CELL;
      OFS_AUX_PROTECT: srb_mask = MASK_AUX;
      OFS_AUX_OV: srb_mask = MASK_AUX;
      OFS_CFG_ONE: srb_mask = MASK_CFG_ONE;
      OFS_CFG_TWO: srb_mask = MASK_CFG_TWO;
      default: srb_mask = 16'h0000;
    endcase
  endfunction

  // Sticky alert registers, cleared by writing ones
  function automatic logic srb_is_alert(input logic [7:0] a);
    srb_is_alert = (a >= OFS_STATUS_ONE) && (a <= OFS_AUX_OV)
      && (a != OFS_EXTREME_CELL);
  endfunction

  // Block 0 holds status registers, block 1 configuration
  function automatic logic srb_block_of(input logic [7:0] a);
    srb_block_of = (a > OFS_STATUS_LAST);
  endfunction

endpackage

// >>> hw/srb_crc8.sv
// Check byte over one full data word
`timescale 1ns/1ps
`default_nettype none
module srb_crc8 (
  input wire logic [15:0] data, // Whole word, spare and unused bits too
  output logic [7:0] crc // Resulting check byte
);
  import srb_pkg::*;

  always_comb begin
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc = c;
  end
endmodule
`default_nettype wire

// >>> hw/srb_block_gate.sv
// Decides whether a write hits a register block in use
`timescale 1ns/1ps
`default_nettype none
module srb_block_gate #(
  parameter int NBLK = srb_pkg::SRB_NBLK
) (
  input wire logic write, // Request is a write
  input wire logic [7:0] addr, // Target offset
  input wire logic [NBLK-1:0] busy, // Blocks in use by a process
  output logic reject // Write must be dropped
);
  import srb_pkg::*;

  if (NBLK != 2) begin : g_bad_nblk
    $error("srb_block_gate serves exactly two blocks");
  end

  always_comb begin
    reject = write && busy[srb_block_of(addr)];
  end
endmodule
`default_nettype wire

// >>> hw/srb_bank.sv
// Status, fault and alert register bank with write rejection
`timescale 1ns/1ps
`default_nettype none
module srb_bank #(
  parameter logic [15:0] VERSION = 16'h1230, // Arbitrary value
  parameter int NREG = srb_pkg::SRB_NREG
) (
  input wire logic clock, // 100 MHz
  input wire logic rst_n, // Asynchronous, active low
  input wire srb_pkg::srb_req_t req, // Decoded host transaction
  input wire logic [srb_pkg::SRB_NBLK-1:0] busy, // Blocks in use
  input wire logic [12:0][15:0] alert_events, // Set pulses per offset
  input wire logic [15:0] extreme_cell, // Live min/max cell indices
  output srb_pkg::srb_rsp_t rsp // Answer, one cycle after request
);
  import srb_pkg::*;

  srb_state_t st;
  srb_state_t next_st;
  logic [7:0] in_crc;
  logic [7:0] out_crc;
  logic gate_reject;
  logic [15:0] rd_word;

  if (NREG != 22) begin : g_bad_nreg
    $error("srb_bank needs 22 register slots");
  end

  // Spare fields must lie inside the stored bits of their registers
  if (!MASK_CFG_ONE[POS_CFG_ONE_SPARE]) begin : g_bad_spare_one
    $error("spare bit of cfg_one is not stored");
  end
  if (MASK_CFG_TWO[POS_CFG_TWO_SPARE +: W_CFG_TWO_SPARE] != 4'hf)
  begin : g_bad_spare_two
    $error("spare field of cfg_two is not stored");
  end

  srb_crc8 u_in_crc (
    .data(req.data),
    .crc(in_crc)
  );

  srb_crc8 u_out_crc (
    .data(rd_word),
    .crc(out_crc)
  );

  srb_block_gate u_gate (
    .write(req.write),
    .addr(req.addr),
    .busy(busy),
    .reject(gate_reject)
  );

  // Read data; spare fields come back as stored
  always_comb begin
    rd_word = 16'h0000;
    if (req.addr == OFS_VERSION_INFO) begin
      rd_word = VERSION;
    end else if (req.addr == OFS_EXTREME_CELL) begin
      rd_word = extreme_cell & MASK_EXTREME_CELL;
    end else if (req.addr < 8'(NREG)) begin
      rd_word = st.regs[req.addr[4:0]] & srb_mask(req.addr);
    end
  end

  always_comb begin
    logic [15:0] set_one;
    logic [15:0] set_two;
    logic [15:0] wmask;
    next_st = st;
    set_one = 16'h0000;
    set_two = 16'h0000;
    wmask = srb_mask(req.addr);
    next_st.rsp.valid = 1'b0;
    next_st.rsp.rejected = 1'b0;
    if (req.valid) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data = 16'h0000;
      next_st.rsp.check = CRC_INIT;
      if (req.proto_err) begin
        set_one[POS_S1_INTERFACE] = 1'b1;
        set_two[POS_S2_SERIAL] = 1'b1;
        next_st.rsp.rejected = 1'b1;
      end else if (req.write && (in_crc != req.check)) begin
        set_one[POS_S1_PEC] = 1'b1;
        next_st.rsp.rejected = 1'b1;
      end else if (req.write) begin
        if (gate_reject) begin
          set_two[POS_S2_REJECTED] = 1'b1;
          next_st.rsp.rejected = 1'b1;
        end else if (srb_is_alert(req.addr)) begin
          next_st.regs[req.addr[4:0]] =
            st.regs[req.addr[4:0]] & ~(req.data & wmask);
        end else if (wmask != 16'h0000) begin
          if (req.addr != OFS_EXTREME_CELL) begin
            // Unused bits dropped, spare fields kept
            next_st.regs[req.addr[4:0]] = req.data & wmask;
          end
        end
      end else begin
        next_st.rsp.data = rd_word;
        next_st.rsp.check = out_crc;
      end
    end
    // Events applied after clears, so a set in the clear cycle wins
    for (int i = 2; i <= 12; i++) begin
      if (i != 10) begin
        next_st.regs[i] = next_st.regs[i]
          | (alert_events[i] & srb_mask(8'(i)));
      end
    end
    next_st.regs[OFS_STATUS_ONE[4:0]] =
      next_st.regs[OFS_STATUS_ONE[4:0]] | set_one;
    next_st.regs[OFS_STATUS_TWO[4:0]] =
      next_st.regs[OFS_STATUS_TWO[4:0]] | set_two;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
endmodule
`default_nettype wire

// >>> test/srb_bank_checker.sv
// Assertion checker for the status register bank
`timescale 1ns/1ps
`default_nettype none
module srb_bank_checker (
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset
  input wire srb_pkg::srb_req_t req, // Request
  input wire logic [1:0] busy, // Busy blocks
  input wire logic [15:0] extreme_cell, // Cell index
  input wire srb_pkg::srb_rsp_t rsp // Answer
);
  import srb_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_rd;
    req.valid && !req.write && !req.proto_err;
  endsequence
  sequence s_rej;
    rsp.valid && rsp.rejected && rsp.data == 16'h0000;
  endsequence
  AST_RD_SERVED: assert property (
    s_rd |=> rsp.valid && !rsp.rejected)
    else $error("read not answered");
  AST_QUIET: assert property (
    !req.valid |=> !rsp.valid)
    else $error("answer without request");
  AST_BUSY_DROP: assert property (
    req.valid && req.write && busy[req.addr > 8'h0c] |=> s_rej)
    else $error("busy write not rejected");
  AST_PROTO: assert property (
    req.valid && req.proto_err |=> s_rej)
    else $error("protocol error not rejected");
  AST_WR_NODATA: assert property (
    req.valid && req.write |=> rsp.check == 8'h00)
    else $error("write answer carries check");
  AST_GAP_ZERO: assert property (
    s_rd ##0 req.addr inside {[8'h0d:8'h13]} |=> rsp.data == 16'h0000)
    else $error("unmapped read not zero");
  AST_EXTREME: assert property (
    s_rd ##0 req.addr == 8'h0a
    |=> rsp.data == ($past(extreme_cell) & 16'h0f0f))
    else $error("cell index bits wrong");
  AST_REJ_VALID: assert property (
    rsp.rejected |-> rsp.valid)
    else $error("reject without answer");
endmodule
bind srb_bank srb_bank_checker u_chk (.clock(clock), .rst_n(rst_n),
  .req(req), .busy(busy), .extreme_cell(extreme_cell), .rsp(rsp));
`default_nettype wire

// >>> test/srb_host.sv
// Host controller model issuing register transactions
`timescale 1ns/1ps
`default_nettype none
module srb_host (
  input wire logic clock, // Bank clock
  output var srb_pkg::srb_req_t req, // To bank
  input wire srb_pkg::srb_rsp_t rsp // From bank
);
  import srb_pkg::*;
  initial req = '0;
  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'ha6 : 8'h00);
    end
    return c;
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d, input logic pe, input logic bad,
    output logic [15:0] q, output logic rj, output logic [7:0] ck,
    output logic to);
    @(negedge clock);
    req <= '{1'b1, w, a, d, crc(d) ^ {7'h00, bad}, pe};
    @(negedge clock);
    req.valid <= 1'b0;
    req.data <= ~d;
    to = 1'b1;
    for (int i = 0; i < 4 && to; i++) begin
      if (rsp.valid === 1'b1) to = 1'b0;
      else @(negedge clock);
    end
    q = rsp.data;
    rj = rsp.rejected;
    ck = rsp.check;
  endtask
endmodule
`default_nettype wire

// >>> test/srb_bank_test.sv
// Self-checking test of the status register bank
`timescale 1ns/1ps
`default_nettype none
module srb_bank_test;
  import srb_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  srb_req_t req;
  srb_rsp_t rsp;
  logic [1:0] busy = 2'b00;
  logic [12:0][15:0] alert_events = '0;
  logic [15:0] extreme_cell = 16'h0000;
  int num_errors = 0;
  int n_tests = 0;
  logic [15:0] q;
  logic rj, to;
  logic [7:0] ck;
  srb_bank u_srb_bank (.clock(clock), .rst_n(rst_n), .req(req),
    .busy(busy), .alert_events(alert_events),
    .extreme_cell(extreme_cell), .rsp(rsp));
  srb_host u_srb_host (.clock(clock), .req(req), .rsp(rsp));
  initial forever #5 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xf(input logic w, input logic [7:0] a,
    input logic [15:0] d, input logic pe = 1'b0, input logic bad = 1'b0);
    u_srb_host.xfer(w, a, d, pe, bad, q, rj, ck, to);
    if (to !== 1'b0) begin
      num_errors++;
      finish_test();
    end else if (!w && !pe) begin
      check({8'h00, ck}, {8'h00, u_srb_host.crc(q)});
    end
  endtask
  task automatic t_spare();
    xf(1'b1, OFS_CFG_ONE, 16'h0008);
    check({15'h0, rj}, 16'h0000);
    xf(1'b0, OFS_CFG_ONE, 16'h0000);
    check(q, 16'h0008);
    xf(1'b1, OFS_CFG_TWO, 16'hffff);
    xf(1'b0, OFS_CFG_TWO, 16'h0000);
    check(q, 16'hef77);
    xf(1'b1, OFS_CFG_TWO, 16'h0500);
    xf(1'b0, OFS_CFG_TWO, 16'h0000);
    check(q, 16'h0500);
  endtask
  task automatic t_proto();
    xf(1'b1, OFS_CHAIN_ADDRESS, 16'hffe0, 1'b1);
    check({15'h0, rj}, 16'h0001);
    xf(1'b0, OFS_CHAIN_ADDRESS, 16'h0000);
    check(q, 16'h0000);
    xf(1'b0, OFS_STATUS_ONE, 16'h0000);
    check(q & 16'h0010, 16'h0010);
    xf(1'b0, OFS_STATUS_TWO, 16'h0000);
    check(q & 16'h0080, 16'h0080);
    xf(1'b1, OFS_CHAIN_ADDRESS, 16'hffe0, 1'b0, 1'b1);
    check({15'h0, rj}, 16'h0001);
    xf(1'b0, OFS_STATUS_ONE, 16'h0000);
    check(q & 16'h0020, 16'h0020);
    xf(1'b0, OFS_CHAIN_ADDRESS, 16'h0000);
    check(q, 16'h0000);
    xf(1'b0, OFS_STATUS_TWO, 16'h0000);
    check(q & 16'h0001, 16'h0000);
  endtask
  task automatic t_busy();
    busy = 2'b01;
    xf(1'b1, OFS_CHAIN_ADDRESS, 16'h0020);
    check({15'h0, rj}, 16'h0001);
    xf(1'b1, OFS_CFG_ONE, 16'h0000);
    check({15'h0, rj}, 16'h0000);
    busy = 2'b10;
    xf(1'b1, OFS_CFG_ONE, 16'h1234);
    check({15'h0, rj}, 16'h0001);
    xf(1'b0, OFS_CFG_ONE, 16'h0000);
    check(q, 16'h0000);
    xf(1'b0, OFS_STATUS_TWO, 16'h0000);
    check(q & 16'h0001, 16'h0001);
    busy = 2'b00;
    xf(1'b1, OFS_STATUS_TWO, 16'h0001);
    xf(1'b0, OFS_STATUS_TWO, 16'h0000);
    check(q & 16'h0001, 16'h0000);
    xf(1'b1, OFS_CHAIN_ADDRESS, 16'hffff);
    xf(1'b0, OFS_CHAIN_ADDRESS, 16'h0000);
    check(q, 16'hffe0);
  endtask
  // Event held across a clearing write: the set must win
  task automatic t_events();
    alert_events[OFS_STATUS_TWO] = 16'h0001;
    alert_events[OFS_STATUS_THREE] = 16'hffff;
    xf(1'b1, OFS_STATUS_TWO, 16'h0001);
    alert_events = '0;
    xf(1'b0, OFS_STATUS_TWO, 16'h0000);
    check(q & 16'h0001, 16'h0001);
    xf(1'b0, OFS_STATUS_THREE, 16'h0000);
    check(q, 16'hf800);
    xf(1'b1, OFS_STATUS_TWO, 16'h0001);
    xf(1'b0, OFS_STATUS_TWO, 16'h0000);
    check(q & 16'h0001, 16'h0000);
  endtask
  task automatic t_read();
    extreme_cell = 16'hffff;
    xf(1'b0, OFS_EXTREME_CELL, 16'h0000);
    check(q, 16'h0f0f);
    xf(1'b0, 8'h10, 16'h0000);
    check(q, 16'h0000);
  endtask
  // Mid-run reset clears stored fields and sticky flags
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    xf(1'b0, OFS_CFG_TWO, 16'h0000);
    check(q, 16'h0000);
    xf(1'b0, OFS_STATUS_TWO, 16'h0000);
    check(q, 16'h0000);
  endtask
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    t_spare();
    t_proto();
    t_busy();
    t_events();
    t_read();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
